/* File: bfr_cfg.svh */
// constants for the bus fault recovery unit
`ifndef BFR_CFG_SVH
`define BFR_CFG_SVH
`define BFR_SSW_OFFSET 8'h0A
`define BFR_SHORT_B_ADD 32'h0000_0004
`define BFR_SHORT_C_ADD 32'h0000_0002
`define BFR_LONG_C_SUB 32'h0000_0002
`define BFR_BIT_FC 15
`define BFR_BIT_FB 14
`define BFR_BIT_RC 13
`define BFR_BIT_RB 12
`define BFR_BIT_DF 8
`define BFR_BIT_RM 7
`define BFR_BIT_RW 6
`define BFR_SIZE_HI 5
`define BFR_SIZE_LO 4
`define BFR_SPACE_HI 2
`define BFR_SPACE_LO 0
`define BFR_WRITABLE_MASK 16'h3100
`define BFR_VEC_ADDR_ERR 12'h00C
`define BFR_VEC_BUS_ERR 12'h008
`define BFR_FMT_SHORT 4'hA
`define BFR_FMT_LONG 4'hB
`define BFR_SPACE_UPROG 3'h2
`define BFR_SPACE_SPROG 3'h6
`endif

/* File: bfr_pkg.sv */
// types for the bus fault recovery unit
package bfr_pkg;
  typedef struct packed {
    logic stage_c_fault;
    logic stage_b_fault;
    logic stage_c_rerun;
    logic stage_b_rerun;
    logic [2:0] zero_hi;
    logic data_fault_flag;
    logic locked_cycle_flag;
    logic read_dir;
    logic [1:0] size;
    logic zero_lo;
    logic [2:0] data_space_code;
  } bfr_ssw_t;
  typedef struct packed {
    logic read_dir;
    logic locked;
    logic [1:0] size;
    logic [2:0] space;
  } bfr_dcyc_t;
  typedef enum logic [3:0] {
    BFR_IDLE = 4'b0001,
    BFR_FAULT = 4'b0010,
    BFR_RETURN = 4'b0100,
    BFR_RERUN = 4'b1000
  } bfr_state_t;
endpackage : bfr_pkg

/* File: bfr_ssw_build.sv */
// builds the fault status word from fault causes
`timescale 1ns/1ns
`default_nettype none
`include "bfr_cfg.svh"
module bfr_ssw_build (
  // causes
  input wire logic addr_err_in,
  input wire logic both_stages_in,
  input wire logic [1:0] stage_used_bad_in,
  input wire logic [1:0] stage_pf_fault_in,
  input wire logic data_fault_in,
  input wire bfr_pkg::bfr_dcyc_t dcyc_in,
  // word
  output bfr_pkg::bfr_ssw_t ssw_out
);
  always_comb
  begin
    ssw_out = '0;
    if (addr_err_in)
    begin
      ssw_out.stage_c_rerun = 1'b1;
      ssw_out.stage_b_rerun = both_stages_in;
    end
    else
    begin
      ssw_out.stage_c_fault = stage_used_bad_in[1];
      ssw_out.stage_b_fault = stage_used_bad_in[0];
      ssw_out.stage_c_rerun = stage_pf_fault_in[1] | stage_used_bad_in[1];
      ssw_out.stage_b_rerun = stage_pf_fault_in[0] | stage_used_bad_in[0];
      ssw_out.data_fault_flag = data_fault_in;
      if (data_fault_in)
      begin
        ssw_out.locked_cycle_flag = dcyc_in.locked;
        ssw_out.read_dir = dcyc_in.read_dir;
        ssw_out.size = dcyc_in.size;
        ssw_out.data_space_code = dcyc_in.space;
      end
    end
  end
endmodule : bfr_ssw_build
`default_nettype wire

/* File: bfr_ret_decide.sv */
// decides which cycles the exception return reruns
`timescale 1ns/1ns
`default_nettype none
`include "bfr_cfg.svh"
module bfr_ret_decide (
  // stacked values
  input wire bfr_pkg::bfr_ssw_t ssw_in,
  input wire logic [1:0] stage_needed_in,
  // decisions
  output logic [1:0] pf_rerun_out,
  output logic data_rerun_out,
  output logic rmw_done_out
);
  always_comb
  begin
    pf_rerun_out[1] = ssw_in.stage_c_rerun & (ssw_in.stage_c_fault | stage_needed_in[1]);
    pf_rerun_out[0] = ssw_in.stage_b_rerun & (ssw_in.stage_b_fault | stage_needed_in[0]);
    data_rerun_out = ssw_in.data_fault_flag;
    rmw_done_out = ssw_in.locked_cycle_flag & ~ssw_in.data_fault_flag;
  end
endmodule : bfr_ret_decide
`default_nettype wire

/* File: bfr_top.sv */
// bus fault recovery unit top
`timescale 1ns/1ns
`default_nettype none
`include "bfr_cfg.svh"
module bfr_top (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  // memory bus cycle end
  input wire logic CYC_END_IN,
  input wire logic BUS_ERR_IN,
  input wire logic CYC_IS_DATA_IN,
  input wire bfr_pkg::bfr_dcyc_t DCYC_IN,
  // instruction stream
  input wire logic IADDR_ODD_REQ_IN,
  input wire logic PIPE_BOTH_IN,
  input wire logic [1:0] STAGE_USE_IN,
  input wire logic [1:0] STAGE_PF_ERR_IN,
  input wire logic [31:0] PC_IN,
  input wire logic LONG_FRAME_REQ_IN,
  // exception return
  input wire logic RET_START_IN,
  input wire logic [15:0] STACK_SSW_IN,
  input wire logic STACK_SR_SUPER_IN,
  input wire logic [1:0] STAGE_NEEDED_IN,
  input wire logic [31:0] STACK_B_ADDR_IN,
  input wire logic STACK_LONG_IN,
  // fault frame outputs
  output logic EXC_START_OUT,
  output logic [15:0] SSW_OUT,
  output logic [7:0] SSW_OFFSET_OUT,
  output logic [3:0] FRAME_FMT_OUT,
  output logic [11:0] VEC_OFFSET_OUT,
  output logic [31:0] STAGE_B_ADDR_OUT,
  output logic [31:0] STAGE_C_ADDR_OUT,
  output logic BUS_START_BLOCK_OUT,
  // rerun outputs
  output logic [1:0] PF_RERUN_OUT,
  output logic [2:0] PF_SPACE_OUT,
  output logic DATA_RERUN_OUT,
  output logic RMW_DONE_OUT,
  output logic RET_DONE_OUT
);
  bfr_pkg::bfr_state_t state_reg, state_next;
  bfr_pkg::bfr_ssw_t ssw_built, ssw_stacked;
  logic [1:0] pf_dec;
  logic data_dec, rmw_dec;
  logic data_err, addr_err, stage_bad, any_fault;
  logic exc_reg, exc_next, blk_reg, blk_next, done_reg, done_next;
  logic [15:0] ssw_reg, ssw_next;
  logic [3:0] fmt_reg, fmt_next;
  logic [11:0] vec_reg, vec_next;
  logic [31:0] badr_reg, badr_next, cadr_reg, cadr_next;
  logic [1:0] pfr_reg, pfr_next;
  logic [2:0] sp_reg, sp_next;
  logic dr_reg, dr_next, rmw_reg, rmw_next;
  logic [7:0] off_reg, off_next;
  logic long_fault;

  assign ssw_stacked = bfr_pkg::bfr_ssw_t'(STACK_SSW_IN);
  assign data_err = CYC_END_IN & BUS_ERR_IN & CYC_IS_DATA_IN;
  assign addr_err = IADDR_ODD_REQ_IN;
  assign stage_bad = |(STAGE_USE_IN & STAGE_PF_ERR_IN);
  assign any_fault = data_err | addr_err | stage_bad;
  assign long_fault = (data_err & DCYC_IN.read_dir) | LONG_FRAME_REQ_IN;

  bfr_ssw_build u_build (
    .addr_err_in(addr_err),
    .both_stages_in(PIPE_BOTH_IN),
    .stage_used_bad_in(STAGE_USE_IN & STAGE_PF_ERR_IN),
    .stage_pf_fault_in(STAGE_PF_ERR_IN),
    .data_fault_in(data_err),
    .dcyc_in(DCYC_IN),
    .ssw_out(ssw_built)
  );

  bfr_ret_decide u_dec (
    .ssw_in(ssw_stacked),
    .stage_needed_in(STAGE_NEEDED_IN),
    .pf_rerun_out(pf_dec),
    .data_rerun_out(data_dec),
    .rmw_done_out(rmw_dec)
  );

  // fault and return sequencing
  always_comb
  begin
    state_next = state_reg;
    exc_next = 1'b0;
    done_next = 1'b0;
    // hold off bus start
    blk_next = addr_err;
    off_next = `BFR_SSW_OFFSET;
    case (state_reg)
      bfr_pkg::BFR_IDLE:
      begin
        if (any_fault)
        begin
          exc_next = 1'b1;
          state_next = bfr_pkg::BFR_FAULT;
        end
        else if (RET_START_IN)
        begin
          state_next = bfr_pkg::BFR_RETURN;
        end
      end
      bfr_pkg::BFR_FAULT:
      begin
        state_next = bfr_pkg::BFR_IDLE;
      end
      bfr_pkg::BFR_RETURN:
      begin
        state_next = bfr_pkg::BFR_RERUN;
      end
      bfr_pkg::BFR_RERUN:
      begin
        done_next = 1'b1;
        state_next = bfr_pkg::BFR_IDLE;
      end
      default:
      begin
        state_next = bfr_pkg::BFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_reg <= bfr_pkg::BFR_IDLE;
      exc_reg <= 1'b0;
      blk_reg <= 1'b0;
      done_reg <= 1'b0;
      off_reg <= `BFR_SSW_OFFSET;
    end
    else
    begin
      state_reg <= state_next;
      exc_reg <= exc_next;
      blk_reg <= blk_next;
      done_reg <= done_next;
      off_reg <= off_next;
    end
  end

  // status word, format and vector
  always_comb
  begin
    ssw_next = ssw_reg;
    fmt_next = fmt_reg;
    vec_next = vec_reg;
    case (state_reg)
      bfr_pkg::BFR_IDLE:
      begin
        if (any_fault)
        begin
          ssw_next = 16'(ssw_built);
          vec_next = addr_err ? `BFR_VEC_ADDR_ERR : `BFR_VEC_BUS_ERR;
          // long or short frame format
          if (long_fault)
          begin
            fmt_next = `BFR_FMT_LONG;
          end
          else
          begin
            fmt_next = `BFR_FMT_SHORT;
          end
        end
      end
      bfr_pkg::BFR_RETURN:
      begin
        ssw_next = STACK_SSW_IN;
      end
      default:
      begin
        ssw_next = ssw_reg;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ssw_reg <= 16'h0000;
      fmt_reg <= 4'h0;
      vec_reg <= 12'h000;
    end
    else
    begin
      ssw_reg <= ssw_next;
      fmt_reg <= fmt_next;
      vec_reg <= vec_next;
    end
  end

  // pipe stage word addresses
  always_comb
  begin
    badr_next = badr_reg;
    cadr_next = cadr_reg;
    case (state_reg)
      bfr_pkg::BFR_IDLE:
      begin
        if (any_fault)
        begin
          badr_next = PC_IN + `BFR_SHORT_B_ADD;
          if (long_fault)
          begin
            cadr_next = PC_IN + `BFR_SHORT_B_ADD - `BFR_LONG_C_SUB;
          end
          else
          begin
            cadr_next = PC_IN + `BFR_SHORT_C_ADD;
          end
        end
      end
      bfr_pkg::BFR_RETURN:
      begin
        if (STACK_LONG_IN)
        begin
          badr_next = STACK_B_ADDR_IN;
          cadr_next = STACK_B_ADDR_IN - `BFR_LONG_C_SUB;
        end
      end
      default:
      begin
        badr_next = badr_reg;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      badr_reg <= 32'h0000_0000;
      cadr_reg <= 32'h0000_0000;
    end
    else
    begin
      badr_reg <= badr_next;
      cadr_reg <= cadr_next;
    end
  end

  // return rerun decisions
  always_comb
  begin
    pfr_next = 2'b00;
    sp_next = sp_reg;
    dr_next = 1'b0;
    rmw_next = 1'b0;
    case (state_reg)
      bfr_pkg::BFR_RETURN:
      begin
        sp_next = STACK_SR_SUPER_IN ? `BFR_SPACE_SPROG : `BFR_SPACE_UPROG;
        pfr_next = pf_dec;
        dr_next = data_dec;
        rmw_next = rmw_dec;
      end
      default:
      begin
        pfr_next = 2'b00;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pfr_reg <= 2'b00;
      sp_reg <= 3'h0;
      dr_reg <= 1'b0;
      rmw_reg <= 1'b0;
    end
    else
    begin
      pfr_reg <= pfr_next;
      sp_reg <= sp_next;
      dr_reg <= dr_next;
      rmw_reg <= rmw_next;
    end
  end

  assign EXC_START_OUT = exc_reg;
  assign SSW_OUT = ssw_reg;
  assign SSW_OFFSET_OUT = off_reg;
  assign FRAME_FMT_OUT = fmt_reg;
  assign VEC_OFFSET_OUT = vec_reg;
  assign STAGE_B_ADDR_OUT = badr_reg;
  assign STAGE_C_ADDR_OUT = cadr_reg;
  assign BUS_START_BLOCK_OUT = blk_reg;
  assign PF_RERUN_OUT = pfr_reg;
  assign PF_SPACE_OUT = sp_reg;
  assign DATA_RERUN_OUT = dr_reg;
  assign RMW_DONE_OUT = rmw_reg;
  assign RET_DONE_OUT = done_reg;
endmodule : bfr_top
`default_nettype wire

/* File: bfr_checker.sv */
// assertion checker for the bus fault recovery unit
`timescale 1ns/1ns
`default_nettype none
module bfr_checker (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  // causes
  input wire logic CYC_END_IN,
  input wire logic BUS_ERR_IN,
  input wire logic CYC_IS_DATA_IN,
  input wire bfr_pkg::bfr_dcyc_t DCYC_IN,
  input wire logic IADDR_ODD_REQ_IN,
  input wire logic PIPE_BOTH_IN,
  input wire logic [1:0] STAGE_USE_IN,
  input wire logic [1:0] STAGE_PF_ERR_IN,
  input wire logic RET_START_IN,
  input wire logic [15:0] STACK_SSW_IN,
  input wire logic STACK_SR_SUPER_IN,
  input wire logic [1:0] STAGE_NEEDED_IN,
  // results
  input wire logic EXC_START_OUT,
  input wire logic [15:0] SSW_OUT,
  input wire logic [7:0] SSW_OFFSET_OUT,
  input wire logic [3:0] FRAME_FMT_OUT,
  input wire logic [11:0] VEC_OFFSET_OUT,
  input wire logic [31:0] STAGE_B_ADDR_OUT,
  input wire logic [31:0] STAGE_C_ADDR_OUT,
  input wire logic BUS_START_BLOCK_OUT,
  input wire logic [1:0] PF_RERUN_OUT,
  input wire logic [2:0] PF_SPACE_OUT,
  input wire logic DATA_RERUN_OUT,
  input wire logic RMW_DONE_OUT
);
  logic rd1_reg;
  logic rd2_reg;
  wire dbe = CYC_END_IN & BUS_ERR_IN & CYC_IS_DATA_IN;
  wire sfe = |(STAGE_USE_IN & STAGE_PF_ERR_IN);
  wire idle = !EXC_START_OUT & !rd1_reg & !rd2_reg;
  wire ae_ok = IADDR_ODD_REQ_IN & idle;
  wire dflt = dbe & idle & !sfe & !IADDR_ODD_REQ_IN;
  wire ret_ok = RET_START_IN & idle & !dbe & !sfe & !IADDR_ODD_REQ_IN;
  // return busy window
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      {rd1_reg, rd2_reg} <= 2'b00;
    else
      {rd1_reg, rd2_reg} <= {ret_ok, rd1_reg};
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence ret_dec;
    ret_ok ##2 1'b1;
  endsequence
  data_exc_a: assert property (dflt |=> EXC_START_OUT && VEC_OFFSET_OUT == 12'h008)
    else $error("data fault not taken at once");
  data_fields_a: assert property (dflt |=> SSW_OUT[8:0] == {1'b1, $past(DCYC_IN.locked),
    $past(DCYC_IN.read_dir), $past(DCYC_IN.size), 1'b0, $past(DCYC_IN.space)}) else $error("data fields wrong");
  read_long_a: assert property (dflt && DCYC_IN.read_dir |=> FRAME_FMT_OUT == 4'hB)
    else $error("read fault not long frame");
  addr_flags_a: assert property (ae_ok |=> SSW_OUT[15:12] == {3'b001, $past(PIPE_BOTH_IN)}
    && VEC_OFFSET_OUT == 12'h00C) else $error("address error word wrong");
  addr_block_a: assert property (ae_ok |=> BUS_START_BLOCK_OUT)
    else $error("bus start not blocked");
  stage_fault_a: assert property (sfe && idle && !IADDR_ODD_REQ_IN |=>
    SSW_OUT[15:14] == $past(STAGE_USE_IN & STAGE_PF_ERR_IN)) else $error("stage fault flags wrong");
  rerun_cover_a: assert property (EXC_START_OUT |-> (SSW_OUT[15:14] & ~SSW_OUT[13:12]) == 2'b00)
    else $error("fault without rerun");
  ssw_zero_a: assert property (EXC_START_OUT |-> SSW_OUT[11:9] == 3'b000 && !SSW_OUT[3])
    else $error("reserved bits set");
  stage_addr_a: assert property (EXC_START_OUT |-> STAGE_C_ADDR_OUT == STAGE_B_ADDR_OUT - 32'h0000_0002)
    else $error("stage C address wrong");
  offset_fixed_a: assert property (SSW_OFFSET_OUT == 8'h0A)
    else $error("status word offset wrong");
  ret_pf_a: assert property (ret_dec |-> PF_RERUN_OUT ==
    ($past(STACK_SSW_IN[13:12]) & ($past(STACK_SSW_IN[15:14]) | $past(STAGE_NEEDED_IN)))) else $error("rerun wrong");
  ret_data_a: assert property (ret_dec |-> DATA_RERUN_OUT == $past(STACK_SSW_IN[8]) &&
    RMW_DONE_OUT == ($past(STACK_SSW_IN[7]) && !$past(STACK_SSW_IN[8]))) else $error("data rerun wrong");
  ret_space_a: assert property (ret_dec ##0 PF_RERUN_OUT != 2'b00 |->
    PF_SPACE_OUT == ($past(STACK_SR_SUPER_IN) ? 3'h6 : 3'h2)) else $error("rerun space wrong");
endmodule : bfr_checker
bind bfr_top bfr_checker u_bfr_checker (.*);
`default_nettype wire

/* File: bfr_bus_model.sv */
// memory bus and fault handler model
`timescale 1ns/1ns
`default_nettype none
module bfr_bus_model (
  // requests
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic err_in,
  input wire bfr_pkg::bfr_dcyc_t dcyc_in,
  input wire logic [15:0] ssw_in,
  input wire logic fix_in,
  // bus and handler side
  output logic cyc_end_out,
  output logic bus_err_out,
  output logic is_data_out,
  output bfr_pkg::bfr_dcyc_t dcyc_out,
  output logic [15:0] ssw_out
);
  initial {cyc_end_out, bus_err_out, is_data_out, dcyc_out} = '0;
  // idle lines show the inverse of the last value, except cyc_end_out, which goes low
  always @(posedge clk_in)
    if (req_in)
      {cyc_end_out, bus_err_out, is_data_out, dcyc_out} <= {1'b1, err_in, 1'b1, dcyc_in};
    else
      {cyc_end_out, bus_err_out, is_data_out, dcyc_out} <= {1'b0, ~bus_err_out, ~is_data_out, ~dcyc_out};
  assign ssw_out = fix_in ? ssw_in & ~16'h3100 : ssw_in;
endmodule : bfr_bus_model
`default_nettype wire

/* File: testbench.sv */
// self-checking testbench for the bus fault recovery unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic MCLK_IN = 0, RST_N_IN = 0, CYC_END_IN, BUS_ERR_IN, CYC_IS_DATA_IN, m_req = 0, m_err = 0, m_fix = 0;
  logic IADDR_ODD_REQ_IN = 0, PIPE_BOTH_IN = 0, LONG_FRAME_REQ_IN = 0, RET_START_IN = 0;
  logic STACK_SR_SUPER_IN = 0, STACK_LONG_IN = 0, EXC_START_OUT, BUS_START_BLOCK_OUT, DATA_RERUN_OUT;
  logic RMW_DONE_OUT, RET_DONE_OUT;
  bfr_pkg::bfr_dcyc_t DCYC_IN, m_dcyc = '0;
  logic [1:0] STAGE_USE_IN = 0, STAGE_PF_ERR_IN = 0, STAGE_NEEDED_IN = 0, PF_RERUN_OUT;
  logic [31:0] PC_IN = 0, STACK_B_ADDR_IN = 0, STAGE_B_ADDR_OUT, STAGE_C_ADDR_OUT;
  logic [15:0] STACK_SSW_IN, SSW_OUT, h_ssw, t_ssw = 0;
  logic [7:0] SSW_OFFSET_OUT;
  logic [3:0] FRAME_FMT_OUT;
  logic [11:0] VEC_OFFSET_OUT;
  logic [2:0] PF_SPACE_OUT;
  int errors = 0, num_checks = 0;
  assign STACK_SSW_IN = m_fix ? h_ssw : t_ssw;
  bfr_top u_bfr_top (.*);
  bfr_bus_model u_bfr_bus_model (.clk_in(MCLK_IN), .req_in(m_req), .err_in(m_err), .dcyc_in(m_dcyc),
    .ssw_in(SSW_OUT), .fix_in(m_fix), .cyc_end_out(CYC_END_IN), .bus_err_out(BUS_ERR_IN),
    .is_data_out(CYC_IS_DATA_IN), .dcyc_out(DCYC_IN), .ssw_out(h_ssw));
  always #25 MCLK_IN = ~MCLK_IN;
  task automatic tick;
    @(posedge MCLK_IN);
    #1;
  endtask : tick
  task automatic wait_frame(input logic [15:0] s, input logic [3:0] f, input logic [11:0] v);
    for (int i = 0; i < 4 && EXC_START_OUT !== 1'b1; i++)
      tick();
    `CHK(EXC_START_OUT, 1'b1)
    `CHK(SSW_OUT, s)
    `CHK(FRAME_FMT_OUT, f)
    `CHK(VEC_OFFSET_OUT, v)
    `CHK(STAGE_B_ADDR_OUT, PC_IN + 32'h0000_0004)
    `CHK(STAGE_C_ADDR_OUT, PC_IN + 32'h0000_0002)
    `CHK(SSW_OFFSET_OUT, 8'h0A)
    tick();
    PC_IN = PC_IN + 32'h0000_0100;
  endtask : wait_frame
  task automatic data_fault(input bfr_pkg::bfr_dcyc_t d, input logic lng);
    m_req = 1;
    m_err = 1;
    m_dcyc = d;
    LONG_FRAME_REQ_IN = lng;
    tick();
    m_req = 0;
    wait_frame({8'h01, d.locked, d.read_dir, d.size, 1'b0, d.space}, (d.read_dir | lng) ? 4'hB : 4'hA, 12'h008);
    LONG_FRAME_REQ_IN = 0;
  endtask : data_fault
  task automatic cause(input logic ae, input logic [1:0] u, input logic [1:0] e, input logic [15:0] s);
    IADDR_ODD_REQ_IN = ae;
    STAGE_USE_IN = u;
    STAGE_PF_ERR_IN = e;
    tick();
    IADDR_ODD_REQ_IN = 0;
    STAGE_USE_IN = 0;
    STAGE_PF_ERR_IN = 0;
    if (ae)
      `CHK(BUS_START_BLOCK_OUT, 1'b1)
    wait_frame(s, 4'hA, ae ? 12'h00C : 12'h008);
  endtask : cause
  task automatic ret(input logic [15:0] s, input logic sup, input logic [1:0] nd, input logic h);
    logic [1:0] pf;
    pf = s[13:12] & (s[15:14] | nd);
    RET_START_IN = 1;
    t_ssw = s;
    m_fix = h;
    STACK_SR_SUPER_IN = sup;
    STAGE_NEEDED_IN = nd;
    tick();
    RET_START_IN = 0;
    tick();
    `CHK(PF_RERUN_OUT, pf)
    `CHK(DATA_RERUN_OUT, s[8])
    `CHK(RMW_DONE_OUT, s[7] & ~s[8])
    if (pf != 2'b00)
      `CHK(PF_SPACE_OUT, sup ? 3'h6 : 3'h2)
    tick();
    `CHK(RET_DONE_OUT, 1'b1)
    m_fix = 0;
  endtask : ret
  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20) @(posedge MCLK_IN);
    #1 RST_N_IN = 1;
    tick();
    data_fault(7'h6D, 1'b0);
    data_fault(7'h19, 1'b0);
    data_fault(7'h12, 1'b1);
    data_fault(7'h5E, 1'b0);
    cause(1'b1, 2'b00, 2'b00, 16'h2000);
    PIPE_BOTH_IN = 1;
    cause(1'b1, 2'b00, 2'b00, 16'h3000);
    cause(1'b0, 2'b11, 2'b11, 16'hF000);
    cause(1'b0, 2'b01, 2'b11, 16'h7000);
    cause(1'b0, 2'b10, 2'b10, 16'hA000);
    data_fault(7'h21, 1'b0);
    ret(16'h0081, 1'b0, 2'b00, 1'b1);
    for (int n = 0; n < 32; n++)
      ret({n[1:0], n[3:2], 3'b000, n[4], n[0], 7'h00}, n[2], {n[4], n[1]}, 1'b0);
    STACK_LONG_IN = 1;
    STACK_B_ADDR_IN = 32'h0000_4000;
    ret(16'h3000, 1'b1, 2'b01, 1'b0);
    `CHK(STAGE_B_ADDR_OUT, 32'h0000_4000)
    `CHK(STAGE_C_ADDR_OUT, 32'h0000_3FFE)
    STACK_LONG_IN = 0;
    report_and_stop();
  end
  initial
  begin
    #50000;
    errors++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
